// file: cfg_word_pkg.sv
// Package of constants and types for the configuration word decoder
package cfg_word_pkg;
  localparam int unsigned CFG_W = 14;
  localparam logic [13:0] CFG_ERASED = 14'h3fff;
  localparam logic [15:0] CFG_WORD_ADDR = 16'h2007;
  localparam int unsigned BIT_PROG_PROT = 13;
  localparam int unsigned BIT_RSVD_HI = 12;
  localparam int unsigned BIT_DEBUG = 11;
  localparam int unsigned BIT_WRT_HI = 10;
  localparam int unsigned BIT_WRT_LO = 9;
  localparam int unsigned BIT_EE_PROT = 8;
  localparam int unsigned BIT_LOW_VOLT = 7;
  localparam int unsigned BIT_BROWNOUT = 6;
  localparam int unsigned BIT_RSVD_MID_HI = 5;
  localparam int unsigned BIT_RSVD_MID_LO = 4;
  localparam int unsigned BIT_POWERUP_N = 3;
  localparam int unsigned BIT_WATCHDOG = 2;
  localparam int unsigned BIT_OSC_HI = 1;
  localparam int unsigned BIT_OSC_LO = 0;
  localparam logic [13:0] CFG_FORCE_ONES = 14'h1030;
  // Wishbone register byte addresses
  localparam logic [7:0] REG_CFG_WORD = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_DECODE = 8'h0c;
  localparam logic [7:0] REG_WP_LIMIT = 8'h10;
  localparam logic [12:0] WP_LIM_8K_10 = 13'h00ff;
  localparam logic [12:0] WP_LIM_8K_01 = 13'h07ff;
  localparam logic [12:0] WP_LIM_8K_00 = 13'h0fff;
  localparam logic [12:0] WP_TOP_8K = 13'h1fff;
  localparam logic [12:0] WP_LIM_4K_10 = 13'h00ff;
  localparam logic [12:0] WP_LIM_4K_01 = 13'h03ff;
  localparam logic [12:0] WP_LIM_4K_00 = 13'h07ff;
  localparam logic [12:0] WP_TOP_4K = 13'h0fff;
  typedef enum logic [1:0] {
    OSC_LOW_POWER = 2'b00,
    OSC_STD = 2'b01,
    OSC_FAST = 2'b10,
    OSC_RES_CAP = 2'b11
  } osc_mode_t;
  typedef enum logic [1:0] {
    WP_RANGE_00 = 2'b00,
    WP_RANGE_01 = 2'b01,
    WP_RANGE_10 = 2'b10,
    WP_OFF = 2'b11
  } wp_code_t;
endpackage : cfg_word_pkg

// file: wp_range_check.sv
// Self-write protection range decode and address check
`timescale 1ns/1ps
module wp_range_check
  import cfg_word_pkg::*;
(
  // Settings
  input wire logic [1:0] self_write_protect_range_i,
  input wire logic large_variant_i,
  // Address check
  input wire logic [12:0] wr_addr_i,
  output logic blocked_o,
  output logic [12:0] limit_o,
  output logic any_prot_o
);
  logic [12:0] top;

  always_comb begin
    limit_o = '0;
    any_prot_o = 1'b1;
    top = large_variant_i ? WP_TOP_8K : WP_TOP_4K;
    unique case (wp_code_t'(self_write_protect_range_i))
      WP_OFF: begin
        any_prot_o = 1'b0;
      end
      WP_RANGE_10: begin
        limit_o = large_variant_i ? WP_LIM_8K_10 : WP_LIM_4K_10; // [RULE_07] [RULE_08]
      end
      WP_RANGE_01: begin
        limit_o = large_variant_i ? WP_LIM_8K_01 : WP_LIM_4K_01; // [RULE_07] [RULE_08]
      end
      WP_RANGE_00: begin
        limit_o = large_variant_i ? WP_LIM_8K_00 : WP_LIM_4K_00; // [RULE_07] [RULE_08]
      end
    endcase
    // Beyond the top of the array is not memory, so it is never writable
    blocked_o = (wr_addr_i > top) || (any_prot_o && (wr_addr_i <= limit_o)); // [RULE_07] [RULE_08]
  end
endmodule : wp_range_check

// file: config_word_decoder.sv
// Configuration word store, programming access and decoded device settings
// Functional notes
// RULE_01: Programmed bits read as 0, unprogrammed bits read as 1.
// RULE_02: Erased word holds all fourteen bits set to one.
// RULE_03: Word lives at fixed address above user space, reachable only while programming.
// RULE_04: Top bit 0 protects all program memory; 1 leaves it unprotected.
// RULE_05: Bit 12 and bits 5-4 always read as 1.
// RULE_06: Debug bit 0 enables debugger and takes two port pins; 1 leaves GPIO.
// RULE_07: Large variant write-protect: 11 none, 10 to 00ff, 01 to 07ff, 00 to 0fff.
// RULE_08: Small variant write-protect: 11 none, 10 to 00ff, 01 to 03ff, 00 to 07ff.
// RULE_09: Data EEPROM protection bit 0 protects, 1 leaves unprotected.
// RULE_10: Low-voltage bit 1 makes shared pin program entry; 0 keeps it digital I/O.
// RULE_11: Brown-out reset active when its bit is 1.
// RULE_12: Power-up timer runs when its bit is 0, bypassed when 1.
// RULE_13: Watchdog enabled when its bit is 1.
// RULE_14: Low two bits select oscillator: 11 res-cap, 10 fast, 01 standard, 00 low-power.
// RULE_15: Decoded outputs captured at reset release, held constant during operation.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module config_word_decoder
  import cfg_word_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Programming mode pin and variant strap
  input wire logic prog_mode_i,
  input wire logic large_variant_i,
  // Self-write address check
  input wire logic [12:0] self_write_addr_i,
  output logic self_write_blocked_o,
  // Decoded settings
  output logic prog_mem_protect_o,
  output logic debug_enable_o,
  output logic debug_pin_a_dedicated_o,
  output logic debug_pin_b_dedicated_o,
  output logic [1:0] self_write_protect_range_o,
  output logic eeprom_protect_o,
  output logic low_volt_prog_enable_o,
  output logic prog_entry_input_sel_o,
  output logic brownout_reset_enable_o,
  output logic powerup_timer_enable_n_o,
  output logic powerup_timer_run_o,
  output logic watchdog_enable_o,
  output logic [1:0] osc_select_o,
  output logic osc_low_power_crystal_o,
  output logic osc_std_crystal_o,
  output logic osc_high_speed_crystal_o,
  output logic osc_res_cap_o
);
  logic prog_meta_r;
  logic prog_sync_r;
  logic [CFG_W-1:0] cfg_store_r;
  logic [CFG_W-1:0] cfg_live_r;
  logic [CFG_W-1:0] cfg_view;
  // Power-up state, so only the very first reset erases the store
  logic loaded_r = 1'b0;
  logic variant_meta_r;
  logic variant_sync_r;
  logic pend_r;
  logic [1:0] wp_limit_sel_r;
  logic wb_req;
  logic wr_ok;
  logic prog_req;
  logic is_word;
  logic is_ctrl;
  logic [12:0] wp_limit;
  logic wp_any;
  logic [1:0] osc_field;

  // Programming mode pin comes from outside, so two flops first
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prog_meta_r <= 1'b0;
      prog_sync_r <= 1'b0;
    end else begin
      prog_meta_r <= prog_mode_i;
      prog_sync_r <= prog_meta_r;
    end
  end

  // Variant strap is a pin; not reset, so it settles while reset is held
  always_ff @(posedge core_clk_i) begin
    variant_meta_r <= large_variant_i;
    variant_sync_r <= variant_meta_r;
  end

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign is_word = (wb_adr_i == REG_CFG_WORD);
  assign is_ctrl = (wb_adr_i == REG_CTRL);
  // Config word window is open only during programming
  assign prog_req = wb_req && is_word && prog_sync_r; // [RULE_03]
  assign wr_ok = prog_req && wb_we_i;

  // Nonvolatile word; only the very first reset erases it, after that only programming does
  always_ff @(posedge core_clk_i) begin
    if (reset_i && !loaded_r) begin
      cfg_store_r <= CFG_ERASED; // [RULE_02]
    end else if (wb_req && is_ctrl && wb_we_i && wb_sel_i[0] && wb_dat_i[0] && prog_sync_r) begin
      cfg_store_r <= CFG_ERASED; // [RULE_02]
    end else if (wr_ok) begin
      // Programming only clears bits; a 1 leaves the bit as it was
      if (wb_sel_i[0]) begin
        cfg_store_r[7:0] <= cfg_store_r[7:0] & wb_dat_i[7:0]; // [RULE_01]
      end
      if (wb_sel_i[1]) begin
        cfg_store_r[13:8] <= cfg_store_r[13:8] & wb_dat_i[13:8]; // [RULE_01]
      end
    end
  end

  // Marks that the store has been initialised once
  always_ff @(posedge core_clk_i) begin
    loaded_r <= 1'b1;
  end

  assign cfg_view = cfg_store_r | CFG_FORCE_ONES; // [RULE_05]

  // Live copy is taken after reset release and frozen until next reset
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pend_r <= 1'b1;
      cfg_live_r <= CFG_ERASED;
    end else if (pend_r) begin
      pend_r <= 1'b0;
      cfg_live_r <= cfg_view; // [RULE_15]
    end
  end

  // Control bits 2:1, only read back through the control register; the limit register does not use them
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wp_limit_sel_r <= 2'b00;
    end else if (wb_req && is_ctrl && wb_we_i && wb_sel_i[0]) begin
      wp_limit_sel_r <= wb_dat_i[2:1];
    end
  end

  wp_range_check i_wp_range_check (
    .self_write_protect_range_i(cfg_live_r[BIT_WRT_HI:BIT_WRT_LO]),
    .large_variant_i(variant_sync_r),
    .wr_addr_i(self_write_addr_i),
    .blocked_o(self_write_blocked_o),
    .limit_o(wp_limit),
    .any_prot_o(wp_any)
  );

  // Single-cycle ack; unmapped or closed config word answers with err
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
      if (wb_req) begin
        unique case (wb_adr_i)
          REG_CFG_WORD: begin
            wb_ack_o <= prog_sync_r; // [RULE_03]
            wb_err_o <= !prog_sync_r; // [RULE_03]
            wb_dat_o <= prog_sync_r ? {18'h00000, cfg_view} : 32'h00000000; // [RULE_01] [RULE_05]
          end
          REG_CTRL: begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= {29'h00000000, wp_limit_sel_r, 1'b0};
          end
          REG_STATUS: begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= {28'h0000000, variant_sync_r, wp_any, !pend_r, prog_sync_r};
          end
          REG_DECODE: begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= {18'h00000, cfg_live_r};
          end
          REG_WP_LIMIT: begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= {19'h00000, wp_limit};
          end
          default: begin
            wb_err_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // Decoded settings, all from the frozen live copy
  assign prog_mem_protect_o = !cfg_live_r[BIT_PROG_PROT]; // [RULE_04] [RULE_15]
  assign debug_enable_o = !cfg_live_r[BIT_DEBUG]; // [RULE_06]
  assign debug_pin_a_dedicated_o = !cfg_live_r[BIT_DEBUG]; // [RULE_06]
  assign debug_pin_b_dedicated_o = !cfg_live_r[BIT_DEBUG]; // [RULE_06]
  assign self_write_protect_range_o = cfg_live_r[BIT_WRT_HI:BIT_WRT_LO]; // [RULE_07]
  assign eeprom_protect_o = !cfg_live_r[BIT_EE_PROT]; // [RULE_09]
  assign low_volt_prog_enable_o = cfg_live_r[BIT_LOW_VOLT]; // [RULE_10]
  assign prog_entry_input_sel_o = cfg_live_r[BIT_LOW_VOLT]; // [RULE_10]
  assign brownout_reset_enable_o = cfg_live_r[BIT_BROWNOUT]; // [RULE_11]
  assign powerup_timer_enable_n_o = cfg_live_r[BIT_POWERUP_N]; // [RULE_12]
  assign powerup_timer_run_o = !cfg_live_r[BIT_POWERUP_N]; // [RULE_12]
  assign watchdog_enable_o = cfg_live_r[BIT_WATCHDOG]; // [RULE_13]
  assign osc_field = cfg_live_r[BIT_OSC_HI:BIT_OSC_LO];
  assign osc_select_o = osc_field; // [RULE_14]
  assign osc_low_power_crystal_o = (osc_mode_t'(osc_field) == OSC_LOW_POWER); // [RULE_14]
  assign osc_std_crystal_o = (osc_mode_t'(osc_field) == OSC_STD); // [RULE_14]
  assign osc_high_speed_crystal_o = (osc_mode_t'(osc_field) == OSC_FAST); // [RULE_14]
  assign osc_res_cap_o = (osc_mode_t'(osc_field) == OSC_RES_CAP); // [RULE_14]
endmodule : config_word_decoder

// file: config_word_decoder_chk.sv
// Checker for bus answers and decoded settings
`timescale 1ns/1ps
module config_word_decoder_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Write protection
  input wire logic large_variant_i,
  input wire logic [12:0] self_write_addr_i,
  input wire logic self_write_blocked_o,
  input wire logic [1:0] self_write_protect_range_o,
  // Settings
  input wire logic prog_mem_protect_o,
  input wire logic debug_enable_o,
  input wire logic debug_pin_b_dedicated_o,
  input wire logic low_volt_prog_enable_o,
  input wire logic prog_entry_input_sel_o,
  input wire logic powerup_timer_enable_n_o,
  input wire logic powerup_timer_run_o,
  input wire logic watchdog_enable_o,
  input wire logic [1:0] osc_select_o,
  input wire logic osc_res_cap_o,
  input wire logic osc_low_power_crystal_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  chk_answer_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o != wb_err_o)
    else $error("no single answer one cycle after a request");
  chk_err_single: assert property (wb_err_o |=> !wb_err_o)
    else $error("error answer held too long");
  chk_debug_pins: assert property (debug_pin_b_dedicated_o == debug_enable_o)
    else $error("debug pin takeover differs from debug enable");
  chk_shared_pin: assert property (prog_entry_input_sel_o == low_volt_prog_enable_o)
    else $error("shared pin function differs from low voltage enable");
  chk_powerup_polarity: assert property (powerup_timer_run_o != powerup_timer_enable_n_o)
    else $error("power-up timer run has wrong polarity");
  chk_osc_decode: assert property (osc_res_cap_o == (osc_select_o == 2'b11) &&
    osc_low_power_crystal_o == (osc_select_o == 2'b00)) else $error("oscillator one-hot wrong");
  chk_wp_large: assert property (large_variant_i && self_write_protect_range_o == 2'b01 |->
    self_write_blocked_o == (self_write_addr_i <= 13'h07ff)) else $error("large variant block wrong");
  chk_wp_small: assert property (!large_variant_i && self_write_protect_range_o == 2'b01 |->
    self_write_blocked_o == (self_write_addr_i <= 13'h03ff || self_write_addr_i > 13'h0fff))
    else $error("small variant block wrong");
  chk_reset_erased: assert property ($fell(reset_i) |-> osc_res_cap_o && watchdog_enable_o && !prog_mem_protect_o)
    else $error("settings during reset are not the erased ones");
  // Two quiet cycles needed: the load edge itself changes outputs
  chk_frozen_view: assert property (!$past(reset_i) && !$past(reset_i, 2) |->
    $stable({prog_mem_protect_o, debug_enable_o, osc_select_o, watchdog_enable_o, self_write_protect_range_o}))
    else $error("decoded settings moved during operation");
endmodule : config_word_decoder_chk
bind config_word_decoder config_word_decoder_chk i_config_word_decoder_chk (.*);

// file: cfg_programmer.sv
// Programmer model: programming mode entry and bus cycles
`timescale 1ns/1ps
module cfg_programmer (
  // Clock
  input wire logic clk_i,
  // Bus answers
  input wire logic ack_i,
  input wire logic err_i,
  input wire logic [31:0] dat_i,
  // Bus requests and mode pin
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  output logic prog_mode_o
);
  initial begin
    {cyc_o, stb_o, we_o, prog_mode_o} = 4'h0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // Mode entry, then margin for the two-flop sync
  task automatic set_prog(input logic on);
    @(posedge clk_i);
    prog_mode_o <= on;
    repeat (3) @(posedge clk_i);
  endtask : set_prog
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic hung);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= a;
    sel_o <= 4'h3;
    dat_o <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ack_i && !err_i && n < 64);
    q = dat_i;
    e = err_i;
    hung = !(ack_i || err_i);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released address and data lines show garbage, never the last value; we_o and sel_o keep theirs
    adr_o <= ~a;
    dat_o <= ~d;
  endtask : xfer
endmodule : cfg_programmer

// file: config_word_decoder_tb.sv
// Testbench: program words, reset, check decoded settings
`timescale 1ns/1ps
module config_word_decoder_tb
  import cfg_word_pkg::*;
;
  typedef struct packed {logic [13:0] w; logic big; logic [12:0] a; logic blk; logic [3:0] osc;} row_t;
  row_t rows [7] = '{'{14'h3fff, 1'b1, 13'h0000, 1'b0, 4'h8}, '{14'h0402, 1'b1, 13'h00ff, 1'b1, 4'h4},
    '{14'h23cd, 1'b1, 13'h07ff, 1'b1, 4'h2}, '{14'h0900, 1'b1, 13'h1000, 1'b0, 4'h1},
    '{14'h0203, 1'b0, 13'h0400, 1'b0, 4'h8}, '{14'h3800, 1'b0, 13'h07ff, 1'b1, 4'h1},
    '{14'h0401, 1'b0, 13'h0100, 1'b0, 4'h2}};
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic large_variant_i = 1'b1;
  logic [12:0] self_write_addr_i = 13'h0000;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, prog_mode_i, self_write_blocked_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic prog_mem_protect_o, debug_enable_o, debug_pin_a_dedicated_o, debug_pin_b_dedicated_o, eeprom_protect_o;
  logic low_volt_prog_enable_o, prog_entry_input_sel_o, brownout_reset_enable_o, powerup_timer_enable_n_o;
  logic powerup_timer_run_o, watchdog_enable_o, osc_low_power_crystal_o, osc_std_crystal_o;
  logic osc_high_speed_crystal_o, osc_res_cap_o, e, hung;
  logic [1:0] self_write_protect_range_o, osc_select_o;
  logic [13:0] w;
  logic [19:0] exp_vec;
  int errors = 0;
  int cmp_count = 0;
  wire [19:0] got_vec = {prog_mem_protect_o, debug_enable_o, debug_pin_a_dedicated_o, debug_pin_b_dedicated_o,
    self_write_protect_range_o, eeprom_protect_o, low_volt_prog_enable_o, prog_entry_input_sel_o,
    brownout_reset_enable_o, powerup_timer_enable_n_o, powerup_timer_run_o, watchdog_enable_o, osc_select_o,
    osc_res_cap_o, osc_high_speed_crystal_o, osc_std_crystal_o, osc_low_power_crystal_o, self_write_blocked_o};
  always #5 core_clk_i = ~core_clk_i;
  cfg_programmer i_cfg_programmer (.clk_i(core_clk_i), .ack_i(wb_ack_o), .err_i(wb_err_o), .dat_i(wb_dat_o),
    .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i),
    .prog_mode_o(prog_mode_i));
  config_word_decoder i_config_word_decoder (.*);
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    i_cfg_programmer.xfer(we, a, d, q, e, hung);
    if (hung) begin
      errors++;
      give_verdict();
    end
  endtask : bus
  task automatic pulse_reset;
    reset_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask : pulse_reset
  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      w = rows[i].w;
      i_cfg_programmer.set_prog(1'b1);
      bus(1'b1, REG_CTRL, 32'h1);
      bus(1'b1, REG_CFG_WORD, {18'h0, w});
      bus(1'b0, REG_CFG_WORD, 32'h0);
      cmp("word", {18'h0, w | CFG_FORCE_ONES}, q);
      i_cfg_programmer.set_prog(1'b0);
      large_variant_i <= rows[i].big;
      self_write_addr_i <= rows[i].a;
      pulse_reset();
      exp_vec = {~w[13], {3{~w[11]}}, w[10:9], ~w[8], {2{w[7]}}, w[6], w[3], ~w[3], w[2], w[1:0],
        rows[i].osc, rows[i].blk};
      cmp("protect", {26'h0, exp_vec[19:14]}, {26'h0, got_vec[19:14]});
      cmp("pins", {28'h0, exp_vec[13:10]}, {28'h0, got_vec[13:10]});
      cmp("timing", {23'h0, exp_vec[9:1]}, {23'h0, got_vec[9:1]});
      cmp("blocked", {31'h0, exp_vec[0]}, {31'h0, got_vec[0]});
      bus(1'b0, REG_DECODE, 32'h0);
      cmp("live", {18'h0, w | CFG_FORCE_ONES}, q);
      $display("row %0d done", i);
    end
    // Programming only clears bits; live view waits for reset
    i_cfg_programmer.set_prog(1'b1);
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b0, REG_CFG_WORD, 32'h0);
    cmp("erased", 32'h3fff, q);
    bus(1'b1, REG_CFG_WORD, 32'h00ff);
    bus(1'b1, REG_CFG_WORD, 32'h3f0f);
    bus(1'b0, REG_DECODE, 32'h0);
    cmp("live held", 32'h1431, q);
    $display("test program done");
    i_cfg_programmer.set_prog(1'b0);
    bus(1'b1, REG_CFG_WORD, 32'h0);
    cmp("hidden err", 32'h1, {31'h0, e});
    bus(1'b0, 8'h14, 32'h0);
    cmp("unmapped err", 32'h1, {31'h0, e});
    $display("test refusal done");
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    cmp("reset view", 32'h3, {29'h0, prog_mem_protect_o, osc_res_cap_o, watchdog_enable_o});
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    bus(1'b0, REG_DECODE, 32'h0);
    cmp("new live", 32'h103f, q);
    $display("test reset done");
    // Erase command outside programming must leave the store alone
    bus(1'b1, REG_CTRL, 32'h7);
    bus(1'b0, REG_CTRL, 32'h0);
    cmp("ctrl", 32'h6, q);
    bus(1'b0, REG_STATUS, 32'h0);
    cmp("status", 32'h6, q);
    bus(1'b0, REG_WP_LIMIT, 32'h0);
    cmp("limit", 32'h7ff, q);
    i_cfg_programmer.set_prog(1'b1);
    bus(1'b0, REG_CFG_WORD, 32'h0);
    cmp("kept", 32'h103f, q);
    $display("test status done");
    give_verdict();
  end
endmodule : config_word_decoder_tb
